// ==== hw/sscs_clkgen.sv ====
// Sample-rate clock phase sequencer; phase 0 after start is always the idle phase
module sscs_clkgen
   import sscs_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       run_in,
   input  wire logic [7:0] divider_in,
   input  wire logic       swap_in,
   output logic            tick_out,
   output logic            idle_ph_out
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       idle_ph;
   } sscs_gen_s;

   sscs_gen_s  q;
   sscs_gen_s  d;
   logic [8:0] half_odd;
   logic [7:0] low_len;
   logic [7:0] high_len;
   logic [7:0] cur_len;
   logic       even_div;

   always_comb begin
      half_odd = ({1'b0, divider_in} + 9'h001) >> 1;
      even_div = (divider_in != 8'h00) && !divider_in[0];
      low_len  = even_div ? (divider_in >> 1) : half_odd[7:0];
      high_len = even_div ? ((divider_in >> 1) + 8'h01) : half_odd[7:0];
      // Zero divider cannot be split below one system cycle per phase
      if (low_len == 8'h00) begin
         low_len = 8'h01;
      end
      if (high_len == 8'h00) begin
         high_len = 8'h01;
      end
      // Idle phase is the low phase for polarity 0, high phase for polarity 1
      cur_len  = (q.idle_ph ^ swap_in) ? low_len : high_len;
      // one idle plus one active phase per bit period
      tick_out = run_in && (q.cnt == cur_len - 8'h01);
      d = q;
      if (!run_in) begin
         d.cnt     = 8'h00;
         d.idle_ph = 1'b1;
      end else if (tick_out) begin
         d.cnt     = 8'h00;
         d.idle_ph = !q.idle_ph;
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
   end

   assign idle_ph_out = q.idle_ph;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '{cnt: 8'h00, idle_ph: 1'b1};
      end else begin
         q <= d;
      end
   end

   property p_gen_idle_when_stopped;
      @(posedge clk_in) disable iff (rst_in)
      !run_in |=> q.idle_ph && (q.cnt == 8'h00);
   endproperty
   a_gen_idle_when_stopped : assert property (p_gen_idle_when_stopped)
      else $error("clock generator not parked while stopped");

endmodule : sscs_clkgen

// ==== hw/sscs_pkg.sv ====
// Contract
// - Slave mode needs sample clock at half CPU rate: source select and divider one.
// - Master with both sync polarities set drives an inverted, active-low slave enable.
// - Slave inverts the active-low enable seen on both frame-sync pins.
// - Master sets transmit clock/sync directions, clears receive ones; slave clears all four.
// - Master lowers enable before the first clock edge, then starts the transfer.
// - Bit clock period is one plus divider, times 2P.
// - Odd or zero divider gives equal phases; even gives low div/2, high div/2+1.
// - Mode 10b polarity 0: enable leads by low phase, trails one full period.
// - Mode 11b polarity 0: enable leads by full period, trails low phase.
// - Mode 10b polarity 1: enable leads by high phase, trails one full period.
// - Mode 10b polarity 0: each output bit launched on rising clock edge; code drives the first bit when the word starts, later bits on rising edges.
// - Mode 11b polarity 0 and 10b polarity 1: output bits launched on falling edge.
// - Polarity 0: input sampled on falling clock edge in both modes.
// - Mode 10b polarity 1: input sampled on rising clock edge.
// - Master releases data one phase after last bit in 10b, at it in 11b.
// - Slave in 10b releases data when the enable returns high.
// - Slave presents first bit on enable low, without waiting for a clock edge.
package sscs_pkg;

   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned CLK_SYS_HZ = 20_000_000;

   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_TXDATA = 4'h4;
   localparam logic [3:0] OFF_RXDATA = 4'h8;
   localparam logic [3:0] OFF_STATUS = 4'hC;

   localparam logic [1:0] MODE_NO_DELAY = 2'h2;
   localparam logic [1:0] MODE_DELAY    = 2'h3;

   // Lead phases before the first active edge, per mode
   localparam logic [5:0] LEAD_NO_DELAY = 6'h01;
   localparam logic [5:0] LEAD_DELAY    = 6'h03;

   typedef struct packed {
      logic [7:0] rsvd_hi;
      logic [7:0] sample_clock_divider;
      logic [4:0] rsvd_mid;
      logic       sample_clock_source_sel;
      logic       rx_sync_dir;
      logic       rx_clock_dir;
      logic       tx_sync_dir;
      logic       tx_clock_dir;
      logic       rx_sync_polarity;
      logic       tx_sync_polarity;
      logic       tx_clock_polarity;
      logic [1:0] clock_stop_mode;
      logic       enable;
   } sscs_ctrl_s;

   typedef struct packed {
      logic [26:0] rsvd;
      logic        overrun;
      logic        cfg_err;
      logic        tx_empty;
      logic        rx_ready;
      logic        busy;
   } sscs_status_s;

   localparam sscs_ctrl_s CTRL_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_MASTER = 2'b01,
      ST_SLAVE  = 2'b10
   } sscs_state_e;

endpackage : sscs_pkg

// ==== hw/sscs_top.sv ====
// The register offsets and the strobed register port were left to the implementer.
module sscs_top
   import sscs_pkg::*;
(
   input  wire logic        CLK_SYS_IN,
   input  wire logic        RST_IN,
   input  wire logic [3:0]  REG_ADDR_IN,
   input  wire logic [31:0] REG_WDATA_IN,
   input  wire logic        REG_WR_IN,
   input  wire logic        REG_RD_IN,
   output logic      [31:0] REG_RDATA_OUT,
   input  wire logic        TX_CLOCK_PIN_IN,
   output logic             TX_CLOCK_PIN_OUT,
   output logic             TX_CLOCK_PIN_OE_OUT,
   input  wire logic        TX_FRAME_SYNC_PIN_IN,
   output logic             TX_FRAME_SYNC_PIN_OUT,
   output logic             TX_FRAME_SYNC_PIN_OE_OUT,
   input  wire logic        RX_FRAME_SYNC_PIN_IN,
   input  wire logic        SERIAL_IN_PIN_IN,
   output logic             SERIAL_OUT_PIN_OUT,
   output logic             SERIAL_OUT_PIN_OE_OUT
);

   typedef struct packed {
      sscs_state_e               state;
      sscs_ctrl_s                ctrl;
      logic [WORD_BITS-1:0]      tx_data;
      logic                      tx_full;
      logic [WORD_BITS-1:0]      rx_data;
      logic                      rx_ready;
      logic                      overrun;
      logic [WORD_BITS-1:0]      tx_sh;
      logic [WORD_BITS-1:0]      rx_sh;
      logic [4:0]                bitcnt;
      logic [5:0]                ph;
      logic                      first;
      logic                      fs_act;
      logic                      clk_act;
      logic                      dout;
      logic                      doe;
      logic                      clk_prev;
      logic [31:0]               rdata;
   } sscs_st_s;

   localparam logic [4:0] BITS_N = 5'(WORD_BITS);

   sscs_st_s     q;
   sscs_st_s     n;
   sscs_status_s status;
   logic         tick;
   logic         idle_ph;
   logic         mode_dly;
   logic         pol;
   logic         master_ok;
   logic         slave_dirs;
   logic         slave_ok;
   logic         en_in;
   logic         clk_norm;
   logic         a_ev;
   logic         b_ev;
   logic         done;
   logic         last_b;
   logic [5:0]   lead;
   logic [5:0]   last_b_ph;
   logic [5:0]   ph_n;
   logic [5:0]   rel_ph;

   sscs_clkgen u_clkgen (
      .clk_in      (CLK_SYS_IN),
      .rst_in      (RST_IN),
      .run_in      (q.state == ST_MASTER),
      .divider_in  (q.ctrl.sample_clock_divider),
      .swap_in     (q.ctrl.tx_clock_polarity),
      .tick_out    (tick),
      .idle_ph_out (idle_ph)
   );

   always_comb begin
      mode_dly   = (q.ctrl.clock_stop_mode == MODE_DELAY);
      pol        = q.ctrl.tx_clock_polarity;
      master_ok  = q.ctrl.tx_clock_dir && q.ctrl.tx_sync_dir
                   && !q.ctrl.rx_clock_dir && !q.ctrl.rx_sync_dir;
      slave_dirs = !q.ctrl.tx_clock_dir && !q.ctrl.tx_sync_dir
                   && !q.ctrl.rx_clock_dir && !q.ctrl.rx_sync_dir;
      slave_ok   = slave_dirs && q.ctrl.sample_clock_source_sel
                   && (q.ctrl.sample_clock_divider == 8'h01);
      en_in      = !TX_FRAME_SYNC_PIN_IN || !RX_FRAME_SYNC_PIN_IN;
      // Clock normalised so that 1 is the active (non-idle) level
      clk_norm   = TX_CLOCK_PIN_IN ^ pol;
      // lead of one idle phase in mode 10b
      lead       = mode_dly ? LEAD_DELAY : LEAD_NO_DELAY;
      last_b_ph  = lead + 6'(2 * WORD_BITS) - 6'h01;
      ph_n       = q.ph + 6'h01;
      done       = (q.bitcnt == BITS_N);
      // A edge leaves the idle level, B edge returns to it
      a_ev = 1'b0;
      b_ev = 1'b0;
      if (q.state == ST_MASTER) begin
         a_ev = tick && idle_ph && (ph_n >= lead) && (ph_n <= last_b_ph);
         b_ev = tick && !idle_ph && (ph_n > lead) && (ph_n <= last_b_ph);
      end else if (q.state == ST_SLAVE) begin
         a_ev = clk_norm && !q.clk_prev && en_in;
         b_ev = !clk_norm && q.clk_prev && en_in;
      end
      last_b = b_ev && (q.bitcnt == BITS_N - 5'h01);
      // mode 10b master release one phase after the last bit
      rel_ph = last_b_ph + 6'h01;

      n          = q;
      n.clk_prev = clk_norm;
      n.rdata    = 32'h0000_0000;

      if (REG_WR_IN) begin
         unique case (REG_ADDR_IN)
            OFF_CTRL: begin
               n.ctrl = REG_WDATA_IN;
            end
            OFF_TXDATA: begin
               n.tx_data = REG_WDATA_IN[WORD_BITS-1:0];
               n.tx_full = 1'b1;
            end
            default: begin
            end
         endcase
      end
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            OFF_CTRL:   n.rdata = q.ctrl;
            OFF_TXDATA: n.rdata = {16'h0000, q.tx_data};
            OFF_RXDATA: begin
               n.rdata    = {16'h0000, q.rx_data};
               n.rx_ready = 1'b0;
               n.overrun  = 1'b0;
            end
            OFF_STATUS: n.rdata = status;
            default:    n.rdata = 32'h0000_0000;
         endcase
      end

      unique case (q.state)
         ST_IDLE: begin
            n.clk_act = 1'b0;
            n.bitcnt  = 5'h00;
            n.ph      = 6'h00;
            n.first   = 1'b1;
            if (q.ctrl.enable && master_ok && q.tx_full) begin
               // enable now, or after one idle phase in mode 11b
               n.state   = ST_MASTER;
               n.fs_act  = !mode_dly;
               n.tx_sh   = q.tx_data;
               // Set wins: a word written in this cycle stays pending
               n.tx_full = REG_WR_IN && (REG_ADDR_IN == OFF_TXDATA);
               n.dout    = q.tx_data[WORD_BITS-1];
               n.doe     = 1'b1;
            end else if (q.ctrl.enable && slave_ok && en_in) begin
               // first bit driven straight from the enable
               n.state   = ST_SLAVE;
               n.tx_sh   = q.tx_full ? q.tx_data : '0;
               n.tx_full = REG_WR_IN && (REG_ADDR_IN == OFF_TXDATA);
               n.dout    = q.tx_full ? q.tx_data[WORD_BITS-1] : 1'b0;
               n.doe     = 1'b1;
            end
         end
         ST_MASTER: begin
            if (tick) begin
               n.ph = ph_n;
            end
            if (tick && ph_n == 6'h01) begin
               n.fs_act = 1'b1;
            end
            if (a_ev) begin
               n.clk_act = 1'b1;
            end
            if (b_ev) begin
               n.clk_act = 1'b0;
            end
            if (tick && mode_dly && ph_n == last_b_ph + 6'h01) begin
               // trail is the idle phase only
               n.fs_act = 1'b0;
               n.state  = ST_IDLE;
            end
            if (tick && !mode_dly && ph_n == rel_ph) begin
               n.doe = 1'b0;
            end
            if (tick && !mode_dly && ph_n == last_b_ph + 6'h02) begin
               n.fs_act = 1'b0;
               n.state  = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (!en_in) begin
               n.doe   = 1'b0;
               n.state = ST_IDLE;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      if (a_ev) begin
         n.first = 1'b0;
         // mode 10b launches on the leaving edge
         if (!mode_dly && !q.first && !done) begin
            n.tx_sh = q.tx_sh << 1;
            n.dout  = q.tx_sh[WORD_BITS-2];
         end
      end
      if (b_ev && !done) begin
         n.rx_sh  = {q.rx_sh[WORD_BITS-2:0], SERIAL_IN_PIN_IN};
         n.bitcnt = q.bitcnt + 5'h01;
         if (mode_dly && !last_b) begin
            // mode 11b launches on the returning edge
            n.tx_sh = q.tx_sh << 1;
            n.dout  = q.tx_sh[WORD_BITS-2];
         end
         if (last_b) begin
            n.rx_data  = {q.rx_sh[WORD_BITS-2:0], SERIAL_IN_PIN_IN};
            n.rx_ready = 1'b1;
            n.overrun  = q.rx_ready && !(REG_RD_IN && REG_ADDR_IN == OFF_RXDATA);
            if (mode_dly) begin
               // release at the last bit in mode 11b
               n.doe = 1'b0;
            end
         end
      end
   end

   always_comb begin
      status          = '0;
      status.busy     = (q.state != ST_IDLE);
      status.rx_ready = q.rx_ready;
      status.tx_empty = !q.tx_full;
      status.cfg_err  = q.ctrl.enable && !master_ok && !slave_ok;
      status.overrun  = q.overrun;
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         q          <= '0;
         q.state    <= ST_IDLE;
         q.ctrl     <= CTRL_RST;
         q.first    <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign REG_RDATA_OUT            = q.rdata;
   assign TX_CLOCK_PIN_OUT         = q.clk_act ^ pol;
   assign TX_CLOCK_PIN_OE_OUT      = q.ctrl.tx_clock_dir;
   // inverted enable when both sync polarities are set
   assign TX_FRAME_SYNC_PIN_OUT    = (q.ctrl.tx_sync_polarity && q.ctrl.rx_sync_polarity)
                                     ? !q.fs_act : q.fs_act;
   assign TX_FRAME_SYNC_PIN_OE_OUT = q.ctrl.tx_sync_dir;
   assign SERIAL_OUT_PIN_OUT       = q.dout;
   assign SERIAL_OUT_PIN_OE_OUT    = q.doe;

   // Helper: cycles since the last A edge, for the period check
   logic [8:0] a_gap_q;
   logic [8:0] period_cyc;
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         a_gap_q <= 9'h000;
      end else begin
         a_gap_q <= a_ev ? 9'h001 : a_gap_q + 9'h001;
      end
   end
   assign period_cyc = (q.ctrl.sample_clock_divider == 8'h00) ? 9'h002
                       : {1'b0, q.ctrl.sample_clock_divider} + 9'h001;

   property p_slave_cfg;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      q.state == ST_SLAVE |-> q.ctrl.sample_clock_source_sel
                              && q.ctrl.sample_clock_divider == 8'h01;
   endproperty
   a_slave_cfg : assert property (p_slave_cfg)
      else $error("slave running with wrong sample clock");

   property p_fs_invert;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (q.state == ST_MASTER && (q.ph != 6'h00 || !mode_dly)
       && q.ctrl.tx_sync_polarity && q.ctrl.rx_sync_polarity)
      |-> !TX_FRAME_SYNC_PIN_OUT;
   endproperty
   a_fs_invert : assert property (p_fs_invert)
      else $error("slave enable not driven low during master word");

   property p_slave_enter;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (q.state == ST_IDLE && q.ctrl.enable && slave_ok && !TX_FRAME_SYNC_PIN_IN
       && !REG_WR_IN)
      |=> q.state == ST_SLAVE && SERIAL_OUT_PIN_OE_OUT;
   endproperty
   a_slave_enter : assert property (p_slave_enter)
      else $error("slave did not drive data on enable");

   property p_master_dirs;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      $rose(q.state == ST_MASTER) |-> $past(master_ok) && TX_CLOCK_PIN_OE_OUT;
   endproperty
   a_master_dirs : assert property (p_master_dirs)
      else $error("master started with wrong directions");

   property p_lead_idle;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      $rose(q.fs_act) |-> (TX_CLOCK_PIN_OUT == pol) [*2];
   endproperty
   a_lead_idle : assert property (p_lead_idle)
      else $error("clock moved as enable asserted");

   property p_period;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (q.state == ST_MASTER && a_ev && !q.first) |-> a_gap_q == period_cyc;
   endproperty
   a_period : assert property (p_period)
      else $error("bit clock period wrong");

   property p_clock_parked;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      q.state != ST_MASTER |-> TX_CLOCK_PIN_OUT == q.ctrl.tx_clock_polarity;
   endproperty
   a_clock_parked : assert property (p_clock_parked)
      else $error("clock not at idle level between words");

   property p_release_dly;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (q.state == ST_MASTER && mode_dly && last_b) |=> !SERIAL_OUT_PIN_OE_OUT;
   endproperty
   a_release_dly : assert property (p_release_dly)
      else $error("data not released at last bit");

   property p_slave_release;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (q.state == ST_SLAVE && !en_in) |=> !SERIAL_OUT_PIN_OE_OUT && q.state == ST_IDLE;
   endproperty
   a_slave_release : assert property (p_slave_release)
      else $error("slave kept data after enable high");

   property p_sample;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (b_ev && !done) |=> q.rx_sh[0] == $past(SERIAL_IN_PIN_IN);
   endproperty
   a_sample : assert property (p_sample)
      else $error("input not sampled on returning edge");

   property p_launch;
      @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (a_ev && !mode_dly && !q.first && !done) |=> SERIAL_OUT_PIN_OUT == $past(q.tx_sh[14]);
   endproperty
   a_launch : assert property (p_launch)
      else $error("bit not launched on leaving edge");

   c_master_word : cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      q.state == ST_MASTER && last_b);
   c_slave_word : cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      q.state == ST_SLAVE && last_b);
   c_master_delay : cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      q.state == ST_MASTER && mode_dly && last_b);

endmodule : sscs_top

// ==== testbench/sscs_peer.sv ====
module sscs_peer
   import sscs_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic role_master_in,
   input  wire logic pol_in,
   input  wire logic dut_sclk_in,
   input  wire logic dut_fs_n_in,
   input  wire logic dut_sdo_in,
   input  wire logic dut_oe_in,
   output logic      sclk_out,
   output logic      fs_n_out,
   output logic      sdi_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] tx_word;
   logic [15:0] rx_word;
   logic [4:0]  nb;
   logic        sc_prev, junk, m_sdi, lead_bit, lead_oe, oe_before, oe_after, sdo_prev;
   wire logic   sc    = role_master_in ? sclk_out : dut_sclk_in;
   wire logic   sel_n = role_master_in ? fs_n_out : dut_fs_n_in;
   // Released data line toggles so a stale bit cannot pass
   assign sdi_out = sel_n ? junk : (role_master_in ? m_sdi : tx_word[4'hF - nb[3:0]]);
   initial begin
      sclk_out = 1'h0;
      fs_n_out = 1'h1;
      m_sdi    = 1'h0;
      junk     = 1'h0;
      nb       = 5'h00;
      sc_prev  = 1'h0;
      tx_word  = 16'h0000;
      rx_word  = 16'h0000;
   end
   // Capture on the return to the idle level, then move to the next bit;
   // the line is taken from before the edge, as mode 11b launches on it
   always @(posedge clk_in) begin
      junk     <= ~junk;
      sc_prev  <= sc;
      sdo_prev <= dut_sdo_in;
      if (sel_n) begin
         nb <= 5'h00;
      end else if (sc != sc_prev && sc == pol_in) begin
         rx_word <= {rx_word[14:0], sdo_prev};
         nb      <= nb + 5'h01;
      end
   end
   // enable low ahead of first edge and for the whole word
   task automatic run_master(input logic [15:0] w);
      logic [15:0] s;
      s = w;
      @(posedge clk_in);
      sclk_out <= pol_in;
      repeat (4) @(posedge clk_in);
      fs_n_out <= 1'h0;
      m_sdi    <= s[15];
      repeat (6) @(posedge clk_in);
      lead_bit = dut_sdo_in;
      lead_oe  = dut_oe_in;
      repeat (16) begin
         sclk_out <= ~pol_in;
         repeat (4) @(posedge clk_in);
         sclk_out <= pol_in;
         // Data moves mid-phase, clear of both edges
         repeat (2) @(posedge clk_in);
         s = s << 1;
         m_sdi <= s[15];
         repeat (2) @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
      oe_before = dut_oe_in;
      fs_n_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      oe_after = dut_oe_in;
   endtask : run_master
endmodule : sscs_peer

// ==== testbench/tb.sv ====
module tb
   import sscs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, r;
   logic        clk, rst, wr, rd, ck_out, ck_oe, fs_out, fs_oe, sdo, sdo_oe;
   logic        p_sclk, p_fs_n, p_sdi, role_v, pol_v, tog, mon_on, sc_q, fs_q, oe_q;
   int          num_errors, total_checks, cyc, t_fs0, t_fs1, t_e1, t_el, t_oe;
   int          hi_m, lo_m, n_e, n_fin;
   wire logic   sclk_ln = ck_oe ? ck_out : p_sclk;
   wire logic   fs_ln   = fs_oe ? fs_out : p_fs_n;
   wire logic   sdo_ln  = sdo_oe ? sdo : tog;

   sscs_top dut (
      .CLK_SYS_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .TX_CLOCK_PIN_IN(sclk_ln), .TX_CLOCK_PIN_OUT(ck_out), .TX_CLOCK_PIN_OE_OUT(ck_oe),
      .TX_FRAME_SYNC_PIN_IN(fs_ln), .TX_FRAME_SYNC_PIN_OUT(fs_out),
      .TX_FRAME_SYNC_PIN_OE_OUT(fs_oe), .RX_FRAME_SYNC_PIN_IN(p_fs_n),
      .SERIAL_IN_PIN_IN(p_sdi), .SERIAL_OUT_PIN_OUT(sdo), .SERIAL_OUT_PIN_OE_OUT(sdo_oe));
   sscs_peer peer (
      .clk_in(clk), .role_master_in(role_v), .pol_in(pol_v), .dut_sclk_in(sclk_ln),
      .dut_fs_n_in(fs_ln), .dut_sdo_in(sdo_ln), .dut_oe_in(sdo_oe),
      .sclk_out(p_sclk), .fs_n_out(p_fs_n), .sdi_out(p_sdi));

   always #25 clk = ~clk;

   task automatic complete_run();
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(posedge clk);
      d = rdata;
   endtask : rd_reg

   function automatic logic [31:0] ctrl_word(input logic [1:0] m, input logic p,
      input logic [7:0] dv, input logic src, input logic ms);
      return {8'h00, dv, 5'h00, src, 2'h0, ms, ms, 2'h3, p, m, 1'h1};
   endfunction : ctrl_word

   // Edge and enable timestamps in system cycles
   always @(posedge clk) begin
      tog <= ~tog;
      cyc++;
      if (fs_ln !== fs_q) begin
         if (fs_ln === 1'h0) begin
            t_fs0 = cyc;
            n_e   = 0;
         end else begin
            t_fs1 = cyc;
            n_fin++;
         end
      end
      if (ck_out !== sc_q) begin
         if (n_e == 0) t_e1 = cyc;
         else if (sc_q) hi_m = cyc - t_el;
         else lo_m = cyc - t_el;
         t_el = cyc;
         n_e++;
      end
      if (oe_q === 1'h1 && sdo_oe === 1'h0) t_oe = cyc;
      if (mon_on && fs_ln === 1'h1) chk_val({31'h0, ck_out}, {31'h0, pol_v});
      sc_q = ck_out;
      fs_q = fs_ln;
      oe_q = sdo_oe;
   end

   task automatic master_run(input logic [1:0] m, input logic p, input logic [7:0] dv,
      input logic [15:0] w);
      int lo, hi, idl, i, k;
      logic nd;
      lo  = dv[0] ? (int'(dv) + 1) / 2 : int'(dv) / 2;
      hi  = dv[0] ? lo : lo + 1;
      idl = p ? hi : lo;
      nd  = (m == MODE_NO_DELAY);
      role_v <= 1'h0;
      pol_v  <= p;
      peer.tx_word = ~w;
      wr_reg(OFF_CTRL, ctrl_word(m, p, dv, 1'h0, 1'h1));
      rd_reg(OFF_CTRL, r);
      chk_val(r, ctrl_word(m, p, dv, 1'h0, 1'h1));
      repeat (4) @(posedge clk);
      chk_val({29'h0, ck_oe, fs_oe, fs_out}, 32'h7);
      mon_on = 1'h1;
      k = n_fin;
      wr_reg(OFF_TXDATA, {16'h0, w});
      for (i = 0; i < 3000 && n_fin == k; i++) @(posedge clk);
      if (n_fin == k) begin
         chk_val(32'(i), 32'h0);
         complete_run();
      end
      mon_on = 1'h0;
      chk_val(32'(hi_m + lo_m), 32'(dv) + 32'h1);
      chk_val(32'(lo_m), 32'(lo));
      chk_val(32'(hi_m), 32'(hi));
      chk_val(32'(n_e), 32'h20);
      chk_val(32'(t_e1 - t_fs0), 32'(nd ? idl : lo + hi));
      chk_val(32'(t_fs1 - t_el), 32'(nd ? lo + hi : idl));
      chk_val(32'(t_oe - t_el), 32'(nd ? idl : 0));
      chk_val({16'h0, peer.rx_word}, {16'h0, w});
      rd_reg(OFF_RXDATA, r);
      chk_val(r, {16'h0, ~w});
   endtask : master_run

   task automatic slave_run(input logic [1:0] m, input logic p, input logic src,
      input logic [15:0] w);
      role_v <= 1'h1;
      pol_v  <= p;
      wr_reg(OFF_CTRL, ctrl_word(m, p, 8'h01, src, 1'h0));
      repeat (4) @(posedge clk);
      chk_val({29'h0, ck_oe, fs_oe, sdo_oe}, 32'h0);
      rd_reg(OFF_STATUS, r);
      chk_val({31'h0, r[3]}, {31'h0, ~src});
      if (src) begin
         wr_reg(OFF_TXDATA, {16'h0, w});
         peer.run_master({w[7:0], w[15:8]});
         chk_val({30'h0, peer.lead_oe, peer.lead_bit}, {30'h0, 1'h1, w[15]});
         chk_val({30'h0, peer.oe_before, peer.oe_after}, {30'h0, m == MODE_NO_DELAY, 1'h0});
         chk_val({16'h0, peer.rx_word}, {16'h0, w});
         rd_reg(OFF_RXDATA, r);
         chk_val(r, {16'h0, w[7:0], w[15:8]});
      end
   endtask : slave_run

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      addr = 4'h0;
      wdata = 32'h0;
      {wr, rd, role_v, pol_v, tog, mon_on, sc_q, oe_q} = 8'h00;
      fs_q = 1'h1;
      {num_errors, total_checks, cyc, n_e, n_fin} = '0;
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      rd_reg(OFF_CTRL, r);
      chk_val(r, 32'h0);
      wr_reg(4'h2, 32'hFFFF_FFFF);
      rd_reg(4'h2, r);
      chk_val(r, 32'h0);
      rd_reg(OFF_CTRL, r);
      chk_val(r, 32'h0);
      master_run(MODE_NO_DELAY, 1'h0, 8'h04, 16'hA5C3);
      master_run(MODE_DELAY, 1'h0, 8'h03, 16'h3C96);
      master_run(MODE_NO_DELAY, 1'h1, 8'h05, 16'h8001);
      slave_run(MODE_NO_DELAY, 1'h0, 1'h1, 16'hC35A);
      slave_run(MODE_DELAY, 1'h0, 1'h1, 16'h0FF1);
      slave_run(MODE_NO_DELAY, 1'h1, 1'h1, 16'h7E81);
      slave_run(MODE_NO_DELAY, 1'h0, 1'h0, 16'h0000);
      complete_run();
   end
endmodule : tb
